/* verilog/edr_consts.vh */
// constants for the embedded dual-port ram block
`ifndef EDR_CONSTS_VH
`define EDR_CONSTS_VH
`define EDR_ARRAY_BITS   4608
`define EDR_LANE_BITS    9
`define EDR_LANES        512
`define EDR_DATA_BITS    4096
`endif

/* verilog/edr_port.v */
// one port of the ram: input registers and output stage
`timescale 1ns/1ps
`default_nettype none
module edr_port #(
	parameter W     = 36,
	parameter AW    = 7,
	parameter BEW   = 4,
	parameter PIPE  = 1
) (
	input  wire          clk_i,
	input  wire          ce_i,
	input  wire          oclr_n_i,
	input  wire [AW-1:0] addr_i,
	input  wire [W-1:0]  data_i,
	input  wire          we_i,
	input  wire [BEW-1:0] be_i,
	input  wire [W-1:0]  rd_i,
	output reg  [AW-1:0] addr_reg,
	output reg  [W-1:0]  data_reg,
	output reg           we_reg,
	output reg  [BEW-1:0] be_reg,
	output wire [W-1:0]  q_o
);
	reg [W-1:0] q_reg;

	// ----------------------------------------------------------------
	// input registers, no clear
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (ce_i) begin
			addr_reg <= addr_i;
			data_reg <= data_i;
			we_reg   <= we_i;
			be_reg   <= be_i;
		end
	end

	// ----------------------------------------------------------------
	// output register, cleared only asynchronously
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge oclr_n_i) begin
		if (!oclr_n_i) begin
			q_reg <= {W{1'b0}};
		end else if (ce_i) begin
			q_reg <= rd_i;
		end
	end

	assign q_o = (PIPE != 0) ? q_reg : rd_i;
endmodule // edr_port
`default_nettype wire

/* verilog/edr_ram.v */
// embedded dual-port ram block top: shared 4608-bit array and two ports
`timescale 1ns/1ps
`default_nettype none
`include "edr_consts.vh"
module edr_ram #(
	parameter WA    = 36,
	parameter AWA   = 7,
	parameter BEA   = 4,
	parameter PIPEA = 1,
	parameter WB    = 9,
	parameter AWB   = 9,
	parameter BEB   = 1,
	parameter PIPEB = 1
) (
	input  wire           clk_a_i,
	input  wire           clk_b_i,
	input  wire           ce_a_i,
	input  wire           ce_b_i,
	input  wire           rst_n_i,
	input  wire           device_wide_clear_n_i,
	input  wire [AWA-1:0] addr_a_i,
	input  wire [WA-1:0]  data_a_i,
	input  wire           we_a_i,
	input  wire [BEA-1:0] be_a_i,
	input  wire [AWB-1:0] addr_b_i,
	input  wire [WB-1:0]  data_b_i,
	input  wire           we_b_i,
	input  wire [BEB-1:0] be_b_i,
	output wire [WA-1:0]  q_a_o,
	output wire [WB-1:0]  q_b_o
);
	// widths of 9,18,36 keep the ninth bits; 1..32 use only data bits
	localparam NA = (WA % 9 == 0) ? `EDR_ARRAY_BITS : `EDR_DATA_BITS;
	localparam NB = (WB % 9 == 0) ? `EDR_ARRAY_BITS : `EDR_DATA_BITS;

	// flat bit array; ninth bits are ordinary storage, parity is not checked
	reg [`EDR_ARRAY_BITS-1:0] mem;

	wire          oclr_n = rst_n_i & device_wide_clear_n_i;
	reg           clr_meta_reg;
	reg           clr_sync_reg;
	wire [AWA-1:0] ad_a;
	wire [WA-1:0]  dt_a;
	wire           wr_a;
	wire [BEA-1:0] bs_a;
	wire [AWB-1:0] ad_b;
	wire [WB-1:0]  dt_b;
	wire           wr_b;
	wire [BEB-1:0] bs_b;
	reg  [WA-1:0]  rd_a;
	reg  [WB-1:0]  rd_b;

	// ----------------------------------------------------------------
	// output clear synchroniser
	// ----------------------------------------------------------------
	// clear takes hold at once but lets go only after two clk_a edges, so
	// port a's output register never leaves clear inside a setup window; port b's is released on clk_a too
	always @(posedge clk_a_i or negedge oclr_n) begin
		if (!oclr_n) begin
			clr_meta_reg <= 1'b0;
			clr_sync_reg <= 1'b0;
		end else begin
			clr_meta_reg <= 1'b1;
			clr_sync_reg <= clr_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// bit position mapping
	// ----------------------------------------------------------------
	// narrow shapes (x1..x32) skip every ninth storage bit
	function integer edr_pos;
		input integer n;
		input integer wide;
		begin
			if (wide == `EDR_ARRAY_BITS)
				edr_pos = n;
			else
				edr_pos = (n / 8) * `EDR_LANE_BITS + (n % 8);
		end
	endfunction

	// byte lane that a word bit belongs to
	function integer edr_lane;
		input integer i;
		input integer w;
		begin
			edr_lane = (w % 9 == 0) ? i / 9 : i / 8;
		end
	endfunction

	edr_port #(.W(WA), .AW(AWA), .BEW(BEA), .PIPE(PIPEA)) u_pa (
		.clk_i    (clk_a_i),
		.ce_i     (ce_a_i),
		.oclr_n_i (clr_sync_reg),
		.addr_i   (addr_a_i),
		.data_i   (data_a_i),
		.we_i     (we_a_i),
		.be_i     (be_a_i),
		.rd_i     (rd_a),
		.addr_reg (ad_a),
		.data_reg (dt_a),
		.we_reg   (wr_a),
		.be_reg   (bs_a),
		.q_o      (q_a_o)
	);

	edr_port #(.W(WB), .AW(AWB), .BEW(BEB), .PIPE(PIPEB)) u_pb (
		.clk_i    (clk_b_i),
		.ce_i     (ce_b_i),
		.oclr_n_i (clr_sync_reg),
		.addr_i   (addr_b_i),
		.data_i   (data_b_i),
		.we_i     (we_b_i),
		.be_i     (be_b_i),
		.rd_i     (rd_b),
		.addr_reg (ad_b),
		.data_reg (dt_b),
		.we_reg   (wr_b),
		.be_reg   (bs_b),
		.q_o      (q_b_o)
	);

	// ----------------------------------------------------------------
	// array write and read per port
	// ----------------------------------------------------------------
	// read path is combinational from the registered address; a same-port
	// write shows new data, a write from the other port lands only at a clk_a
	// edge so the other side still sees the old word
	integer i;
	always @* begin
		for (i = 0; i < WA; i = i + 1) begin
			rd_a[i] = mem[edr_pos(ad_a * WA + i, NA)];
			if (wr_a && bs_a[edr_lane(i, WA) % BEA])
				rd_a[i] = dt_a[i];
		end
	end

	integer j;
	always @* begin
		for (j = 0; j < WB; j = j + 1) begin
			rd_b[j] = mem[edr_pos(ad_b * WB + j, NB)];
			if (wr_b && bs_b[edr_lane(j, WB) % BEB])
				rd_b[j] = dt_b[j];
		end
	end

	// both ports write into one array; a real block resolves the clocks in
	// silicon, here one process on port a samples port b writes too
	integer k;
	integer m;
	always @(posedge clk_a_i) begin
		if (ce_a_i && wr_a) begin
			for (k = 0; k < WA; k = k + 1)
				if (bs_a[edr_lane(k, WA) % BEA])
					mem[edr_pos(ad_a * WA + k, NA)] <= dt_a[k];
		end
		if (ce_b_i && wr_b) begin
			for (m = 0; m < WB; m = m + 1)
				if (bs_b[edr_lane(m, WB) % BEB])
					mem[edr_pos(ad_b * WB + m, NB)] <= dt_b[m];
		end
	end
endmodule // edr_ram
`default_nettype wire

/* verif/edr_chk.sv */
// assertion checker for the dual-port ram block
`timescale 1ns/1ps
`default_nettype none
module edr_chk #(
	parameter WA  = 36,
	parameter BEA = 4,
	parameter WB  = 9
) (
	input wire logic           clk_a_i,
	input wire logic           clk_b_i,
	input wire logic           ce_a_i,
	input wire logic           ce_b_i,
	input wire logic           rst_n_i,
	input wire logic           device_wide_clear_n_i,
	input wire logic [WA-1:0]  data_a_i,
	input wire logic           we_a_i,
	input wire logic [BEA-1:0] be_a_i,
	input wire logic [WA-1:0]  q_a_o,
	input wire logic [WB-1:0]  q_b_o
);
	logic off;
	assign off = !rst_n_i || !device_wide_clear_n_i;
	default clocking @(posedge clk_a_i); endclocking
	default disable iff (!rst_n_i);
	AST_CLR_A: assert property (!device_wide_clear_n_i |-> q_a_o == '0)
		else $error("a not cleared");
	AST_CLR_B: assert property (@(posedge clk_b_i) disable iff (!rst_n_i)
		!device_wide_clear_n_i |-> q_b_o == '0) else $error("b not cleared");
	AST_HOLD_A: assert property (disable iff (off) !ce_a_i |=> $stable(q_a_o))
		else $error("a moved");
	AST_HOLD_B: assert property (@(posedge clk_b_i) disable iff (off)
		!ce_b_i |=> $stable(q_b_o)) else $error("b moved");
	AST_RDW_A: assert property (disable iff (off) ce_a_i && we_a_i && &be_a_i
		##1 ce_a_i |=> q_a_o == $past(data_a_i, 2)) else $error("a no new data");
	AST_ZERO_A: assert property ($rose(rst_n_i) |-> q_a_o == '0)
		else $error("a not zero");
	AST_ZERO_B: assert property (@(posedge clk_b_i) disable iff (!rst_n_i)
		$rose(rst_n_i) |-> q_b_o == '0) else $error("b not zero");
	AST_CLR_HOLD: assert property (!device_wide_clear_n_i ##1 !ce_a_i |=> q_a_o == '0)
		else $error("a lost clear");
endmodule // edr_chk
bind edr_ram edr_chk #(.WA(WA), .BEA(BEA), .WB(WB)) chk_i (.clk_a_i, .clk_b_i, .ce_a_i,
	.ce_b_i, .rst_n_i, .device_wide_clear_n_i, .data_a_i, .we_a_i, .be_a_i, .q_a_o, .q_b_o);
`default_nettype wire

/* verif/edr_user.sv */
// user-side parity helper on the narrow port
`timescale 1ns/1ps
`default_nettype none
module edr_user (
	input  wire logic [7:0] byte_i,
	input  wire logic [8:0] q_i,
	output logic      [8:0] data_o,
	output logic            perr_o
);
	// block stores the ninth bit blindly, so parity lives here
	assign data_o = {^byte_i, byte_i};
	assign perr_o = ^q_i;
endmodule // edr_user
`default_nettype wire

/* verif/embedded_dual_port_ram_block_tb_top.sv */
// testbench for the dual-port ram block
`timescale 1ns/1ps
`default_nettype none
module embedded_dual_port_ram_block_tb_top;
	localparam logic [35:0] X1 = 36'h987654321, X3 = 36'h1a5c3e0f7;
	logic clk = 0, rst_n = 0, dclr_n = 1, ce_a = 0, ce_b = 0, we_a = 0, we_b = 0, perr;
	logic [6:0]  a_a = 0;
	logic [8:0]  a_b = 0, d_b, q_b;
	logic [35:0] d_a = 0, q_a;
	logic [3:0]  be_a = 4'hf;
	logic [7:0]  byt = 0;
	logic [8:0]  wptr = 9'd21;
	int miscompares = 0, tests_run = 0;
	edr_ram uut (.clk_a_i(clk), .clk_b_i(clk), .ce_a_i(ce_a), .ce_b_i(ce_b), .rst_n_i(rst_n),
		.device_wide_clear_n_i(dclr_n), .addr_a_i(a_a), .data_a_i(d_a), .we_a_i(we_a),
		.be_a_i(be_a), .addr_b_i(a_b), .data_b_i(d_b), .we_b_i(we_b), .be_b_i(1'b1),
		.q_a_o(q_a), .q_b_o(q_b));
	edr_user usr (.byte_i(byt), .q_i(q_b), .data_o(d_b), .perr_o(perr));
	initial forever #25 clk = ~clk;
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pa(input logic w, input logic [6:0] ad, input logic [35:0] d,
		input logic [3:0] be);
		we_a = w; a_a = ad; d_a = d; be_a = be;
	endtask
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic t_rdw;
		ce_a = 1; pa(1, 7'd5, X1, 4'hf);
		cyc(1); pa(1, 7'd6, X3, 4'hf);
		cyc(1); pa(0, 7'd5, 36'h0, 4'hf);
		chk(q_a, X1);
		cyc(1); chk(q_a, X3);
		cyc(1); chk(q_a, X1);
	endtask
	task automatic t_be;
		pa(1, 7'd5, 36'h0, 4'h5);
		cyc(1); we_a = 0; cyc(3);
		chk(q_a, X1 & 36'hff803fe00);
	endtask
	task automatic t_mix;
		ce_b = 1; a_b = wptr; pa(1, 7'd5, X3, 4'hf);
		cyc(1); we_a = 0; cyc(1);
		chk(q_b, X1[17:9]);
		cyc(2); chk(q_b, X3[17:9]);
		wptr = wptr + 9'd1;
		a_b = wptr; byt = 8'hc3; we_b = 1;
		cyc(1); we_b = 0; cyc(3);
		chk(q_b, {^8'hc3, 8'hc3});
		chk(perr, 1'b0);
		chk(q_a, {X3[35:27], ^8'hc3, 8'hc3, X3[17:0]});
	endtask
	task automatic t_ce;
		logic [35:0] prev;
		prev = {X3[35:27], ^8'hc3, 8'hc3, X3[17:0]};
		ce_a = 0; ce_b = 0; pa(1, 7'd5, 36'h0, 4'hf);
		cyc(3); we_a = 0; chk(q_a, prev);
		ce_a = 1; cyc(3); chk(q_a, prev);
		rst_n = 0; #1 chk(q_a, 36'h0);
		chk(q_b, 9'h0);
		cyc(1); rst_n = 1; cyc(5); chk(q_a, prev);
		ce_a = 0; dclr_n = 0; #1 chk(q_a, 36'h0);
		cyc(1); dclr_n = 1; cyc(2); chk(q_a, 36'h0);
	endtask
	initial begin
		cyc(20); rst_n = 1; cyc(3);
		chk(q_a, 36'h0);
		chk(q_b, 9'h0);
		t_rdw(); t_be(); t_mix(); t_ce();
		conclude();
	end
	// generous next to the 54 cycles the tasks need
	initial begin
		#100us miscompares++;
		conclude();
	end
endmodule // embedded_dual_port_ram_block_tb_top
`default_nettype wire
